// *** hdl/clock_divider_delay_pkg.sv ***
package clock_divider_delay_pkg;

   // ----------------------------------------
   // Sizes
   // ----------------------------------------
   localparam int NUM_PAIRS = 3;
   localparam int DIV_W = 10;
   localparam int SDIV_W = 13;
   localparam int STEP_W = 8;

   // ----------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STEP = 8'h04;
   localparam logic [7:0] REG_SYSREF_DIVIDE_VALUE = 8'h08;
   localparam logic [7:0] REG_SYSREF_DLY = 8'h0c;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam logic [7:0] REG_PAIR_BASE = 8'h20;
   localparam logic [7:0] REG_PAIR_STRIDE = 8'h04;

   // ----------------------------------------
   // Control register fields
   // ----------------------------------------
   localparam int CTRL_SYNC_TRIGGER_POLARITY = 0;
   localparam int CTRL_SYSREF_DYN_EN = 1;
   localparam int CTRL_SYSREF_RESYNC_BLK = 2;
   localparam int CTRL_INCLK_FORCE = 3;

   // ----------------------------------------
   // Pair register fields
   // ----------------------------------------
   localparam int PAIR_DIV_LSB = 0;
   localparam int PAIR_DLY_LSB = 10;
   localparam int PAIR_PD = 20;
   localparam int PAIR_BLK = 21;
   localparam int PAIR_DYN_EN = 22;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [DIV_W-1:0] RST_DIV = 10'h008;
   localparam logic [DIV_W-1:0] RST_DLY = 10'h008;
   localparam logic [SDIV_W-1:0] RST_SDIV = 13'h012c;
   localparam logic [SDIV_W-1:0] RST_SDLY = 13'h0008;

endpackage : clock_divider_delay_pkg

// *** hdl/phase_divider.sv ***
`timescale 1ns/1ps
// Divider whose period can be replaced by a one-shot alternate count
module phase_divider
   import clock_divider_delay_pkg::*;
#(
   parameter int W = 10
)
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic [W-1:0] divideValue,
   input wire logic [W-1:0] loadValue,
   input wire logic load,
   input wire logic useAlt,
   input wire logic [W-1:0] altValue,
   output logic altTaken,
   output logic clkOut
);
   logic [W-1:0] count;
   logic [W-1:0] period;

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         count <= '0;
         period <= '0;
         clkOut <= 1'b0;
         altTaken <= 1'b0;
      end
      else
      begin
         altTaken <= 1'b0;
         if (load)
         begin
            count <= loadValue;
            period <= loadValue;
            clkOut <= 1'b0;
         end
         else if (count <= 1)
         begin
            period <= useAlt ? altValue : divideValue;
            count <= useAlt ? altValue : divideValue;
            altTaken <= useAlt;
            clkOut <= 1'b1;
         end
         else
         begin
            count <= count - 1'b1;
            if (count <= (period >> 1))
               clkOut <= 1'b0;
         end
      end
   end
endmodule : phase_divider

// *** hdl/clock_divider_digital_delay.sv ***
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
// What this block does
// - Fixed delay loads only on unblocked outputs at the falling edge of an asserted-then-released sync.
// - After sync a pair's delay circuit may be powered down and its applied phase stays.
// - Each enabled device-clock divider uses divide plus one for one period, step-count times.
// - SYSREF adjust uses the global delay minus half the divide as alternate count; divide*1.5+1 shifts one cycle.
// - A larger alternate value delays the adjusted output, a smaller one advances it.
// - Writing step count N adds N cycles of delay on enabled device clocks without touching others; SYSREF shifts per its alternate count.
module clock_divider_digital_delay
   import clock_divider_delay_pkg::*;
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic syncPin,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [31:0] regRdData,
   output logic [NUM_PAIRS-1:0] deviceClock,
   output logic sysrefClock,
   output logic adjustBusy
);

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic syncTriggerPolarity;
   logic sysrefDynamicAdjustEnable;
   logic sysrefResyncBlock;
   logic inputClockForce;
   logic [SDIV_W-1:0] sysrefDivideValue;
   logic [SDIV_W-1:0] sysrefGlobalDelayValue;
   logic [STEP_W-1:0] dynamicAdjustStepCount;
   logic [DIV_W-1:0] pairDivider [NUM_PAIRS];
   logic [DIV_W-1:0] pairFixedDelay [NUM_PAIRS];
   logic [NUM_PAIRS-1:0] pairDelayPowerdown;
   logic [NUM_PAIRS-1:0] outputResyncBlock;
   logic [NUM_PAIRS-1:0] outputDynamicAdjustEnable;
   logic stepWrite;
   logic [NUM_PAIRS-1:0] pairSel;
   logic [NUM_PAIRS-1:0] delayApplied;

   assign stepWrite = regWrite && regAddr == REG_STEP;

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         syncTriggerPolarity <= 1'b0;
         sysrefDynamicAdjustEnable <= 1'b0;
         sysrefResyncBlock <= 1'b0;
         inputClockForce <= 1'b0;
         sysrefDivideValue <= RST_SDIV;
         sysrefGlobalDelayValue <= RST_SDLY;
         dynamicAdjustStepCount <= '0;
      end
      else if (regWrite)
      begin
         unique case (regAddr)
            REG_CTRL:
            begin
               syncTriggerPolarity <= regWrData[CTRL_SYNC_TRIGGER_POLARITY];
               sysrefDynamicAdjustEnable <= regWrData[CTRL_SYSREF_DYN_EN];
               sysrefResyncBlock <= regWrData[CTRL_SYSREF_RESYNC_BLK];
               inputClockForce <= regWrData[CTRL_INCLK_FORCE];
            end
            REG_STEP: dynamicAdjustStepCount <= regWrData[STEP_W-1:0];
            REG_SYSREF_DIVIDE_VALUE: sysrefDivideValue <= regWrData[SDIV_W-1:0];
            REG_SYSREF_DLY: sysrefGlobalDelayValue <= regWrData[SDIV_W-1:0];
            default:
            begin
            end
         endcase
      end
   end

   // ----------------------------------------
   // Sync event detection
   // ----------------------------------------
   logic syncMeta;
   logic syncSafe;
   logic syncLevel;
   logic syncLevelQ;
   logic syncEvent;

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         syncMeta <= 1'b0;
         syncSafe <= 1'b0;
         syncLevelQ <= 1'b0;
      end
      else
      begin
         syncMeta <= syncPin;
         syncSafe <= syncMeta;
         syncLevelQ <= syncLevel;
      end
   end

   assign syncLevel = syncSafe ^ syncTriggerPolarity;
   assign syncEvent = syncLevelQ && !syncLevel;

   // ----------------------------------------
   // Dynamic adjust engine
   // ----------------------------------------
   logic [STEP_W-1:0] pendingSteps [NUM_PAIRS+1];
   logic [NUM_PAIRS:0] altTaken;
   logic [NUM_PAIRS:0] busyVec;

   genvar g;
   generate
      for (g = 0; g <= NUM_PAIRS; g++)
      begin : gen_step
         logic enabled;
         if (g < NUM_PAIRS)
         begin : gen_dev
            assign enabled = outputDynamicAdjustEnable[g];
         end
         else
         begin : gen_sys
            assign enabled = sysrefDynamicAdjustEnable;
         end
         always_ff @(posedge clk_sys)
         begin
            if (sys_rst)
               pendingSteps[g] <= '0;
            else if (stepWrite)
               pendingSteps[g] <= enabled ? regWrData[STEP_W-1:0] : '0;
            else if (altTaken[g] && pendingSteps[g] != 0)
               pendingSteps[g] <= pendingSteps[g] - 1'b1;
         end
         assign busyVec[g] = pendingSteps[g] != 0;
      end
   endgenerate

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
         adjustBusy <= 1'b0;
      else
         adjustBusy <= |busyVec;
   end

   // ----------------------------------------
   // Device clock pairs
   // ----------------------------------------
   generate
      for (g = 0; g < NUM_PAIRS; g++)
      begin : gen_pair
         logic loadPair;
         logic clkRaw;
         assign pairSel[g] = regAddr == REG_PAIR_BASE + REG_PAIR_STRIDE * 8'(g);
         // Load only with delay circuit powered and resync not blocked
         assign loadPair = syncEvent && !outputResyncBlock[g] && !pairDelayPowerdown[g];
         always_ff @(posedge clk_sys)
         begin
            if (sys_rst)
            begin
               pairDivider[g] <= RST_DIV;
               pairFixedDelay[g] <= RST_DLY;
               pairDelayPowerdown[g] <= 1'b1;
               outputResyncBlock[g] <= 1'b0;
               outputDynamicAdjustEnable[g] <= 1'b0;
               delayApplied[g] <= 1'b0;
               deviceClock[g] <= 1'b0;
            end
            else
            begin
               if (regWrite && pairSel[g])
               begin
                  pairDivider[g] <= regWrData[PAIR_DIV_LSB +: DIV_W];
                  pairFixedDelay[g] <= regWrData[PAIR_DLY_LSB +: DIV_W];
                  pairDelayPowerdown[g] <= regWrData[PAIR_PD];
                  outputResyncBlock[g] <= regWrData[PAIR_BLK];
                  outputDynamicAdjustEnable[g] <= regWrData[PAIR_DYN_EN];
               end
               if (loadPair)
                  delayApplied[g] <= 1'b1;
               deviceClock[g] <= clkRaw;
            end
         end
         // Alternate value is divide plus one; phase persists after power-down
         phase_divider #(.W(DIV_W)) u_div
         (
            .clk_sys(clk_sys),
            .sys_rst(sys_rst),
            .divideValue(pairDivider[g]),
            .loadValue(pairFixedDelay[g]),
            .load(loadPair),
            .useAlt(pendingSteps[g] != 0),
            .altValue(pairDivider[g] + 1'b1),
            .altTaken(altTaken[g]),
            .clkOut(clkRaw)
         );
      end
   endgenerate

   // ----------------------------------------
   // SYSREF divider
   // ----------------------------------------
   logic sysrefRaw;

   phase_divider #(.W(SDIV_W)) u_sysref
   (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .divideValue(sysrefDivideValue),
      .loadValue(sysrefGlobalDelayValue),
      .load(syncEvent && !sysrefResyncBlock),
      .useAlt(pendingSteps[NUM_PAIRS] != 0),
      // Global delay counts divide plus half divide, so the half is taken off
      .altValue(sysrefGlobalDelayValue - (sysrefDivideValue >> 1)),
      .altTaken(altTaken[NUM_PAIRS]),
      .clkOut(sysrefRaw)
   );

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
         sysrefClock <= 1'b0;
      else
         sysrefClock <= sysrefRaw;
   end

   // ----------------------------------------
   // Read port
   // ----------------------------------------
   logic [31:0] next_regRdData;
   integer i;

   always_comb
   begin
      next_regRdData = 32'h00000000;
      unique case (regAddr)
         REG_CTRL: next_regRdData = {28'h0000000, inputClockForce, sysrefResyncBlock,
                                     sysrefDynamicAdjustEnable, syncTriggerPolarity};
         REG_STEP: next_regRdData = {24'h000000, dynamicAdjustStepCount};
         REG_SYSREF_DIVIDE_VALUE: next_regRdData = {19'h00000, sysrefDivideValue};
         REG_SYSREF_DLY: next_regRdData = {19'h00000, sysrefGlobalDelayValue};
         REG_STATUS: next_regRdData = {28'h0000000, delayApplied, adjustBusy};
         default:
         begin
            for (i = 0; i < NUM_PAIRS; i++)
               if (pairSel[i])
                  next_regRdData = {9'h000, outputDynamicAdjustEnable[i],
                                    outputResyncBlock[i], pairDelayPowerdown[i],
                                    pairFixedDelay[i], pairDivider[i]};
         end
      endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
         regRdData <= 32'h00000000;
      else if (regRead)
         regRdData <= next_regRdData;
      else
         regRdData <= 32'h00000000;
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence s_syncPulse;
      syncLevel ##1 !syncLevel;
   endsequence

   a_sync_load_block: assert property (@(posedge clk_sys) disable iff (sys_rst)
      s_syncPulse |=> (delayApplied & ~$past(delayApplied)) ==
         ($past(~outputResyncBlock & ~pairDelayPowerdown) & ~$past(delayApplied)))
      else $error("fixed delay applied to a blocked pair");

   a_step_load: assert property (@(posedge clk_sys) disable iff (sys_rst)
      stepWrite && outputDynamicAdjustEnable[1]
         |=> pendingSteps[1] == $past(regWrData[STEP_W-1:0]))
      else $error("step count not loaded on enabled pair");

   a_step_skip: assert property (@(posedge clk_sys) disable iff (sys_rst)
      stepWrite && !outputDynamicAdjustEnable[0] |=> pendingSteps[0] == 0)
      else $error("disabled pair took an adjustment");

   a_sysref_skip: assert property (@(posedge clk_sys) disable iff (sys_rst)
      stepWrite && !sysrefDynamicAdjustEnable |=> pendingSteps[NUM_PAIRS] == 0)
      else $error("sysref adjusted while disabled");

   a_busy_flag: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (|busyVec) |=> adjustBusy)
      else $error("busy flag missed pending steps");

   a_step_count: assert property (@(posedge clk_sys) disable iff (sys_rst)
      altTaken[1] && !stepWrite && pendingSteps[1] != 0
         |=> pendingSteps[1] == $past(pendingSteps[1]) - 1)
      else $error("step not consumed");

   a_kept_phase: assert property (@(posedge clk_sys) disable iff (sys_rst)
      syncEvent && pairDelayPowerdown[2] && pendingSteps[2] == 0
         |=> gen_pair[2].u_div.count == ($past(gen_pair[2].u_div.count) <= 1 ?
            $past(pairDivider[2]) : $past(gen_pair[2].u_div.count) - 1'b1))
      else $error("powered-down pair lost its phase at sync");

   a_read_zero: assert property (@(posedge clk_sys) disable iff (sys_rst)
      !regRead |=> regRdData == 0)
      else $error("read data outside read cycle");

endmodule : clock_divider_digital_delay

// *** dv/clock_receiver_model.sv ***
`timescale 1ns/1ps
// Receiving devices: note the cycle of each clock's latest rising edge
module clock_receiver_model
   import clock_divider_delay_pkg::*;
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic [NUM_PAIRS-1:0] deviceClock,
   input wire logic sysrefClock,
   output int riseAt [NUM_PAIRS+1]
);
   int cyc = 0;
   logic [NUM_PAIRS:0] curClk;
   logic [NUM_PAIRS:0] prevClk;
   assign curClk = {sysrefClock, deviceClock};
   always_ff @(posedge clk_sys)
   begin
      cyc <= cyc + 1;
      prevClk <= sys_rst ? '0 : curClk;
      for (int i = 0; i <= NUM_PAIRS; i++)
      begin
         if (!prevClk[i] && curClk[i])
            riseAt[i] <= cyc;
      end
   end
endmodule : clock_receiver_model

// *** dv/clock_divider_digital_delay_bench.sv ***
`timescale 1ns/1ps
module clock_divider_digital_delay_bench
   import clock_divider_delay_pkg::*;
;
   logic clk_sys, sys_rst, syncPin, regWrite, regRead, rdLast, sysrefClock, adjustBusy;
   logic [7:0] regAddr;
   logic [31:0] regWrData, regRdData, rv;
   logic [NUM_PAIRS-1:0] deviceClock;
   logic [31:0] expQ [$];
   int riseAt [NUM_PAIRS+1];
   int numErrors = 0, checked = 0, seed = 6, cycles = 0, d0, d1;

   clock_divider_digital_delay DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .syncPin(syncPin),
      .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
      .regRdData(regRdData), .deviceClock(deviceClock), .sysrefClock(sysrefClock),
      .adjustBusy(adjustBusy));
   clock_receiver_model rx (.clk_sys(clk_sys), .sys_rst(sys_rst), .deviceClock(deviceClock),
      .sysrefClock(sysrefClock), .riseAt(riseAt));

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         numErrors++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task print_verdict();
      if (numErrors == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : print_verdict
   task wr(input logic [7:0] a, input logic [31:0] d);
      regWrite <= 1'b1;
      regRead <= 1'b0;
      regAddr <= a;
      regWrData <= d;
      @(posedge clk_sys);
   endtask : wr
   task rd(input logic [7:0] a, input logic [31:0] e);
      regRead <= 1'b1;
      regWrite <= 1'b0;
      regAddr <= a;
      expQ.push_back(e);
      @(posedge clk_sys);
   endtask : rd
   task idle(input int n);
      regWrite <= 1'b0;
      regRead <= 1'b0;
      repeat (n) @(posedge clk_sys);
   endtask : idle
   function automatic logic [7:0] pa(input int i);
      return 8'(REG_PAIR_BASE + REG_PAIR_STRIDE * i);
   endfunction : pa
   function automatic logic [31:0] pw(input logic [9:0] dv, dl, input logic pd, bk, dy);
      pw = '0;
      pw[PAIR_DIV_LSB +: DIV_W] = dv;
      pw[PAIR_DLY_LSB +: DIV_W] = dl;
      pw[PAIR_PD] = pd;
      pw[PAIR_BLK] = bk;
      pw[PAIR_DYN_EN] = dy;
   endfunction : pw
   function automatic logic [31:0] ph(input int a, input int b);
      return 32'((((riseAt[a] - riseAt[b]) % 8) + 8) % 8);
   endfunction : ph
   function automatic logic [31:0] sp();
      return 32'(riseAt[NUM_PAIRS] % 16);
   endfunction : sp
   function automatic int divFix(input int dv);
      if (dv > 6 || dv == 4)
         return 0;
      else if (dv == 6)
         return -1;
      else if (dv == 5)
         return 3;
      return -2;
   endfunction : divFix
   task syncPol();
      wr(REG_CTRL, 32'h1);
      idle(6);
      wr(REG_CTRL, 32'h0);
      idle(40);
   endtask : syncPol
   task stepRun(input logic [31:0] n);
      int k;
      wr(REG_STEP, n);
      idle(0);
      k = 0;
      while (adjustBusy !== 1'b1 && k < 8)
      begin
         @(posedge clk_sys);
         k++;
      end
      check(32'(adjustBusy), 32'h1);
      while (adjustBusy !== 1'b0 && k < 400)
      begin
         @(posedge clk_sys);
         k++;
      end
      check(32'(adjustBusy), 32'h0);
      idle(40);
   endtask : stepRun

   // ----------------------------------------
   // Clock, monitor, timeout
   // ----------------------------------------
   initial
   begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys)
   begin
      if (rdLast)
         check(regRdData, expQ.pop_front());
      rdLast <= regRead;
      cycles++;
      if (cycles == 4000)
      begin
         numErrors++;
         print_verdict();
      end
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      sys_rst = 1'b1;
      syncPin = 1'b0;
      regWrite = 1'b0;
      regRead = 1'b0;
      regAddr = 8'h00;
      regWrData = 32'h0;
      rdLast = 1'b0;
      repeat (20) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(posedge clk_sys);
      rd(REG_CTRL, 32'h0);
      rd(REG_SYSREF_DIVIDE_VALUE, 32'(RST_SDIV));
      rd(REG_SYSREF_DLY, 32'(RST_SDLY));
      rd(REG_STATUS, 32'h0);
      for (int i = 0; i < NUM_PAIRS; i++)
         rd(pa(i), pw(RST_DIV, RST_DLY, 1'b1, 1'b0, 1'b0));
      wr(8'h40, 32'hffffffff);
      rd(8'h40, 32'h0);
      wr(REG_CTRL, 32'h6);
      rd(REG_CTRL, 32'h6);
      repeat (4)
      begin
         rv = $random(seed) | (32'h1 << PAIR_PD);
         wr(pa(2), rv);
         rd(pa(2), rv & 32'h7fffff);
         wr(REG_SYSREF_DLY, rv);
         rd(REG_SYSREF_DLY, rv & 32'h1fff);
      end
      wr(REG_CTRL, 32'h0);
      wr(REG_SYSREF_DIVIDE_VALUE, 32'd16);
      wr(REG_SYSREF_DLY, 32'(8 + divFix(8)));
      wr(pa(0), pw(10'd8, 10'd8, 1'b0, 1'b0, 1'b0));
      wr(pa(1), pw(10'd8, 10'd9, 1'b0, 1'b0, 1'b0));
      wr(pa(2), pw(10'd8, 10'd12, 1'b1, 1'b0, 1'b0));
      syncPol();
      rd(REG_STATUS, 32'h6);
      check(ph(1, 0), 32'd1);
      check(ph(3, 0), 32'd0);
      wr(pa(0), pw(10'd8, 10'd8, 1'b1, 1'b1, 1'b0));
      wr(pa(1), pw(10'd8, 10'd9, 1'b1, 1'b1, 1'b0));
      idle(30);
      check(ph(1, 0), 32'd1);
      wr(pa(1), pw(10'd8, 10'd9, 1'b0, 1'b1, 1'b1));
      idle(20);
      d0 = ph(2, 0);
      stepRun(32'd2);
      check(ph(1, 0), 32'd3);
      check(ph(2, 0), 32'(d0));
      wr(REG_SYSREF_DLY, 32'd25);
      wr(REG_CTRL, 32'h2);
      idle(40);
      d1 = sp();
      stepRun(32'd1);
      check(sp(), 32'((d1 + 1) % 16));
      check(ph(1, 0), 32'd4);
      wr(REG_SYSREF_DLY, 32'd23);
      stepRun(32'd1);
      check(sp(), 32'(d1));
      wr(REG_CTRL, 32'h0);
      wr(pa(2), pw(10'd8, 10'd8, 1'b0, 1'b0, 1'b0));
      idle(10);
      d0 = ph(1, 0);
      syncPin <= 1'b1;
      idle(6);
      syncPin <= 1'b0;
      idle(40);
      rd(REG_STATUS, 32'he);
      check(ph(1, 0), 32'(d0));
      idle(4);
      print_verdict();
   end
endmodule : clock_divider_digital_delay_bench
